/* File: bench/pllfb_ctrl_bench.sv */
// self-checking bench for the feedback and receiver-mode register block
// assumes pllfb_pkg and the checker are compiled first
`timescale 1ns/1ps
`include "pllfb_params.svh"

module pllfb_ctrl_bench;
	// ****
	// stimulus and checks
	// ****
	logic                      sys_clk = 1'b0;
	logic                      rst_n = 1'b0;
	logic [9:0]                reg_addr = 10'h000;
	logic [7:0]                reg_wdata = 8'h00;
	logic                      reg_wr_en = 1'b0;
	logic                      reg_rd_en = 1'b0;
	logic                      d1 = 1'b0;
	logic                      d2 = 1'b0;
	logic [7:0]                reg_rdata, rd_data;
	logic                      reg_rd_valid, fb_path_changed;
	pllfb_pkg::pllfb_fb_ctrl_t fb_ctrl;
	pllfb_pkg::pllfb_rx_mode_t zd_m, r1_m, r2_m;
	// decoded path of the reset value, then of each swept value
	logic [3:0]                prev_fb = 4'hb;
	logic [3:0]                cur_fb;
	int                        n_errors = 0, compares = 0, r, seed = 32'h58b77e34;

	always #50 sys_clk = ~sys_clk;

	pllfb_ctrl i_dut (.sys_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr_en, .reg_rd_en,
		.reg_rdata, .reg_rd_valid, .first_ref_diff_en(d1), .second_ref_diff_en(d2),
		.fb_ctrl, .fb_path_changed, .zero_delay_input_mode(zd_m),
		.first_reference_input_mode(r1_m), .second_reference_input_mode(r2_m));

	function automatic logic [3:0] exp_fb(input logic [7:0] v);
		if (v[4])
			return {pllfb_pkg::PLLFB_FB_OSC, 2'b00};
		return v[5] ? {pllfb_pkg::PLLFB_FB_ZD_INTERNAL, 2'b10}
			: {pllfb_pkg::PLLFB_FB_ZD_EXTERNAL, 2'b11};
	endfunction : exp_fb
	// pin choice only matters single-ended: 0 positive, 1 negative
	function automatic logic [3:0] exp_rx(input logic p, input logic df, input logic pin);
		return p ? {1'b1, df, !df && !pin, !df && pin} : 4'h0;
	endfunction : exp_rx

	task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic wr(input logic [9:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr_en <= 1'b1;
		@(posedge sys_clk);
		reg_wr_en <= 1'b0;
	endtask : wr
	task automatic rd(input logic [9:0] a, output logic [7:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd_en <= 1'b1;
		@(posedge sys_clk);
		reg_rd_en <= 1'b0;
		#1;
		chk("rd_valid", {7'h0, reg_rd_valid}, 8'h01);
		d = reg_rdata;
	endtask : rd
	task automatic end_sim();
		$display("compares %0d n_errors %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : end_sim

	initial begin
		repeat (100000) @(posedge sys_clk);
		n_errors++;
		$display("wrong value run length expected end seen hang");
		end_sim();
	end

	initial begin
		repeat (5) @(posedge sys_clk);
		rst_n <= 1'b1;
		rd(`PLLFB_LOOP_FB_ADDR, rd_data);
		chk("reset value", rd_data, 8'h00);
		chk("reset fb", {4'h0, fb_ctrl}, {4'h0, exp_fb(8'h00)});
		$display("test reset done");
		// every value, with random neighbour differential bits
		for (int i = 0; i < 256; i++) begin
			r = $random(seed);
			@(posedge sys_clk);
			d1 <= r[0];
			d2 <= r[1];
			wr(`PLLFB_LOOP_FB_ADDR, i[7:0]);
			@(posedge sys_clk);
			#1;
			cur_fb = exp_fb(i[7:0]);
			chk("fb_ctrl", {4'h0, fb_ctrl}, {4'h0, cur_fb});
			chk("path changed", {7'h0, fb_path_changed}, {7'h0, cur_fb[3:2] != prev_fb[3:2]});
			prev_fb = cur_fb;
			chk("zd", {4'h0, zd_m}, {4'h0, exp_rx(!i[4] && !i[5], i[2], i[3])});
			chk("ref1", {4'h0, r1_m}, {4'h0, exp_rx(1'b1, r[0], i[0])});
			chk("ref2", {4'h0, r2_m}, {4'h0, exp_rx(1'b1, r[1], i[1])});
			rd(`PLLFB_LOOP_FB_ADDR, rd_data);
			chk("readback", rd_data, i[7:0]);
		end
		$display("test sweep done");
		wr(`PLLFB_LOOP_FB_ADDR, 8'h2c);
		wr(10'h01c, 8'hff);
		rd(10'h01c, rd_data);
		chk("unmapped read", rd_data, 8'h00);
		rd(`PLLFB_LOOP_FB_ADDR, rd_data);
		chk("after refused write", rd_data, 8'h2c);
		@(posedge sys_clk);
		reg_wdata <= 8'h91;
		reg_wr_en <= 1'b1;
		reg_rd_en <= 1'b1;
		@(posedge sys_clk);
		reg_wr_en <= 1'b0;
		reg_rd_en <= 1'b0;
		#1;
		chk("same cycle read", reg_rdata, 8'h2c);
		rd(`PLLFB_LOOP_FB_ADDR, rd_data);
		chk("reserved kept", rd_data, 8'h91);
		$display("test access done");
		// reset in mid-run must drop the stored value and the decode
		@(posedge sys_clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge sys_clk);
		rst_n <= 1'b1;
		rd(`PLLFB_LOOP_FB_ADDR, rd_data);
		chk("reset again", rd_data, 8'h00);
		chk("reset again fb", {4'h0, fb_ctrl}, {4'h0, exp_fb(8'h00)});
		chk("reset again zd", {4'h0, zd_m}, {4'h0, exp_rx(1'b1, 1'b0, 1'b0)});
		$display("test mid-run reset done");
		end_sim();
	end
endmodule : pllfb_ctrl_bench

/* File: bench/pllfb_ctrl_chk.sv */
// port-level checker for the feedback and receiver-mode register block
// assumes it is bound onto every pllfb_ctrl instance
`timescale 1ns/1ps
`include "pllfb_params.svh"

module pllfb_ctrl_chk #(
	parameter int ADDR_W = 10
) (
	// clock and reset
	input wire logic                      sys_clk,
	input wire logic                      rst_n,
	// register access
	input wire logic [ADDR_W-1:0]         reg_addr,
	input wire logic [7:0]                reg_wdata,
	input wire logic                      reg_wr_en,
	input wire logic                      reg_rd_en,
	input wire logic [7:0]                reg_rdata,
	input wire logic                      reg_rd_valid,
	// neighbour bits and decoded controls
	input wire logic                      first_ref_diff_en,
	input wire logic                      second_ref_diff_en,
	input wire pllfb_pkg::pllfb_fb_ctrl_t fb_ctrl,
	input wire logic                      fb_path_changed,
	input wire pllfb_pkg::pllfb_rx_mode_t zero_delay_input_mode,
	input wire pllfb_pkg::pllfb_rx_mode_t first_reference_input_mode,
	input wire pllfb_pkg::pllfb_rx_mode_t second_reference_input_mode
);
	// ****
	// properties
	// ****
	logic [1:0] exp_sel;
	always_comb begin
		exp_sel = reg_wdata[4] ? 2'h0 : (reg_wdata[5] ? 2'h1 : 2'h2);
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	property p_wr_fb;
		reg_wr_en && reg_addr == `PLLFB_LOOP_FB_ADDR |-> ##2 fb_ctrl.fb_sel == $past(exp_sel, 2);
	endproperty
	a_wr_fb: assert property (p_wr_fb) else $error("feedback path wrong after write");
	property p_zd_en;
		fb_ctrl.zero_delay_en == (fb_ctrl.fb_sel != pllfb_pkg::PLLFB_FB_OSC);
	endproperty
	a_zd_en: assert property (p_zd_en) else $error("zero delay enable wrong");
	property p_zd_pwr;
		fb_ctrl.zd_rx_power_up == (fb_ctrl.fb_sel == pllfb_pkg::PLLFB_FB_ZD_EXTERNAL);
	endproperty
	a_zd_pwr: assert property (p_zd_pwr) else $error("zero delay power wrong");
	property p_zd_off;
		!fb_ctrl.zd_rx_power_up |-> zero_delay_input_mode == 4'h0;
	endproperty
	a_zd_off: assert property (p_zd_off) else $error("unpowered receiver active");
	property p_zd_pin;
		zero_delay_input_mode.powered |-> zero_delay_input_mode.diff_mode
			!= (zero_delay_input_mode.pos_pin_en ^ zero_delay_input_mode.neg_pin_en);
	endproperty
	a_zd_pin: assert property (p_zd_pin) else $error("zero delay pin choice wrong");
	property p_ref1;
		$past(rst_n) |-> first_reference_input_mode.diff_mode == $past(first_ref_diff_en);
	endproperty
	a_ref1: assert property (p_ref1) else $error("first reference mode wrong");
	property p_ref2;
		$past(rst_n) |-> second_reference_input_mode.diff_mode == $past(second_ref_diff_en);
	endproperty
	a_ref2: assert property (p_ref2) else $error("second reference mode wrong");
	property p_rd;
		$past(rst_n) |-> reg_rd_valid == $past(reg_rd_en);
	endproperty
	a_rd: assert property (p_rd) else $error("read valid timing wrong");
	property p_bad_rd;
		reg_rd_en && reg_addr != `PLLFB_LOOP_FB_ADDR |=> reg_rdata == 8'h00;
	endproperty
	a_bad_rd: assert property (p_bad_rd) else $error("unmapped read not zero");
	property p_chg;
		$past(rst_n) |-> fb_path_changed == (fb_ctrl.fb_sel != $past(fb_ctrl.fb_sel));
	endproperty
	a_chg: assert property (p_chg) else $error("path change pulse wrong");
endmodule : pllfb_ctrl_chk

bind pllfb_ctrl pllfb_ctrl_chk #(.ADDR_W(ADDR_W)) i_chk (.sys_clk, .rst_n, .reg_addr,
	.reg_wdata, .reg_wr_en, .reg_rd_en, .reg_rdata, .reg_rd_valid, .first_ref_diff_en,
	.second_ref_diff_en, .fb_ctrl, .fb_path_changed, .zero_delay_input_mode,
	.first_reference_input_mode, .second_reference_input_mode);

/* File: core/pllfb_ctrl.sv */
// input-loop feedback source and receiver-mode control register
// assumes register accesses arrive as single-cycle strobes on sys_clk
// assumes the neighbouring receiver register supplies the two reference
// differential-enable bits as levels
//
// Functional notes
// - feedback bit set: oscillator input receiver feeds loop, no zero delay
// - feedback bit clear: zero delay on, path chosen by zero-delay-mode bit
// - mode bit set: zero delay receiver off, divider channel 0 fed back
// - mode bit clear: external zero delay, zero delay receiver enabled
// - mode bit ignored while feedback bit is set
// - bit 2 selects differential or single-ended zero delay receiver
// - bit 3 picks zero delay single-ended pin, only while bit 2 clear
// - bit 1 picks second reference pin, only while its differential bit clear
// - bit 0 picks first reference pin, only while its differential bit clear
// - reference differential bits: 1 differential, 0 single-ended default
`timescale 1ns/1ps
`include "pllfb_params.svh"

module pllfb_ctrl #(
	parameter int                       ADDR_W    = `PLLFB_ADDR_W,
	parameter logic [`PLLFB_DATA_W-1:0] RESET_VAL = `PLLFB_LOOP_FB_RESET
) (
	// clock and reset
	input  wire logic                        sys_clk,
	input  wire logic                        rst_n,
	// register access port
	input  wire logic [ADDR_W-1:0]           reg_addr,
	input  wire logic [`PLLFB_DATA_W-1:0]    reg_wdata,
	input  wire logic                        reg_wr_en,
	input  wire logic                        reg_rd_en,
	output logic      [`PLLFB_DATA_W-1:0]    reg_rdata,
	output logic                             reg_rd_valid,
	// neighbouring receiver register bits
	input  wire logic                        first_ref_diff_en,
	input  wire logic                        second_ref_diff_en,
	// decoded feedback controls
	output pllfb_pkg::pllfb_fb_ctrl_t        fb_ctrl,
	output logic                             fb_path_changed,
	// decoded receiver modes
	output pllfb_pkg::pllfb_rx_mode_t        zero_delay_input_mode,
	output pllfb_pkg::pllfb_rx_mode_t        first_reference_input_mode,
	output pllfb_pkg::pllfb_rx_mode_t        second_reference_input_mode
);

	// ****************************************
	// register storage
	// ****************************************
	logic [`PLLFB_DATA_W-1:0] loop_fb_reg;
	logic [`PLLFB_DATA_W-1:0] loop_fb_next;
	logic                     hit;

	always_comb begin
		hit = (reg_addr == ADDR_W'(`PLLFB_LOOP_FB_ADDR));
	end

	always_comb begin
		loop_fb_next = loop_fb_reg;
		// every bit stored, reserved ones included but never decoded
		if (reg_wr_en && hit) begin
			loop_fb_next = reg_wdata;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			loop_fb_reg <= RESET_VAL;
		end else begin
			loop_fb_reg <= loop_fb_next;
		end
	end

	// ****************************************
	// read path
	// ****************************************
	logic [`PLLFB_DATA_W-1:0] rdata_reg;
	logic [`PLLFB_DATA_W-1:0] rdata_next;
	logic                     rd_valid_reg;
	logic                     rd_valid_next;

	always_comb begin
		rdata_next    = rdata_reg;
		rd_valid_next = reg_rd_en;
		if (reg_rd_en) begin
			// unmapped addresses read as zero
			if (hit) begin
				rdata_next = loop_fb_reg;
			end else begin
				rdata_next = '0;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_reg    <= '0;
			rd_valid_reg <= 1'b0;
		end else begin
			rdata_reg    <= rdata_next;
			rd_valid_reg <= rd_valid_next;
		end
	end

	assign reg_rdata    = rdata_reg;
	assign reg_rd_valid = rd_valid_reg;

	// ****************************************
	// feedback path decode
	// ****************************************
	logic                      fb_osc_bit;
	logic                      zd_internal_bit;
	pllfb_pkg::pllfb_fb_ctrl_t fb_dec;

	always_comb begin
		fb_osc_bit      = loop_fb_reg[`PLLFB_BIT_FB_OSC];
		zd_internal_bit = loop_fb_reg[`PLLFB_BIT_ZD_INTERNAL];
		fb_dec.fb_sel         = pllfb_pkg::PLLFB_FB_OSC;
		fb_dec.zero_delay_en  = 1'b0;
		fb_dec.zd_rx_power_up = 1'b0;
		if (fb_osc_bit) begin
			// mode bit not consulted here at all
			fb_dec.fb_sel         = pllfb_pkg::PLLFB_FB_OSC;
			fb_dec.zero_delay_en  = 1'b0;
			// receiver idle: nothing to feed back through it
			fb_dec.zd_rx_power_up = 1'b0;
		end else if (zd_internal_bit) begin
			fb_dec.fb_sel         = pllfb_pkg::PLLFB_FB_ZD_INTERNAL;
			fb_dec.zero_delay_en  = 1'b1;
			fb_dec.zd_rx_power_up = 1'b0;
		end else begin
			fb_dec.fb_sel         = pllfb_pkg::PLLFB_FB_ZD_EXTERNAL;
			fb_dec.zero_delay_en  = 1'b1;
			fb_dec.zd_rx_power_up = 1'b1;
		end
	end

	// ****************************************
	// receiver mode decode
	// ****************************************
	pllfb_pkg::pllfb_rx_mode_t zd_mode_dec;
	pllfb_pkg::pllfb_rx_mode_t first_mode_dec;
	pllfb_pkg::pllfb_rx_mode_t second_mode_dec;

	pllfb_rx_mode u_zd_rx (
		.powered  (fb_dec.zd_rx_power_up),
		.diff_en  (loop_fb_reg[`PLLFB_BIT_ZD_DIFF]),
		.pin_sel  (loop_fb_reg[`PLLFB_BIT_ZD_PIN]),
		.mode     (zd_mode_dec)
	);

	// reference power state lives in the neighbouring register
	pllfb_rx_mode u_first_rx (
		.powered  (1'b1),
		.diff_en  (first_ref_diff_en),
		.pin_sel  (loop_fb_reg[`PLLFB_BIT_FIRST_REF_PIN]),
		.mode     (first_mode_dec)
	);

	pllfb_rx_mode u_second_rx (
		.powered  (1'b1),
		.diff_en  (second_ref_diff_en),
		.pin_sel  (loop_fb_reg[`PLLFB_BIT_SECOND_REF_PIN]),
		.mode     (second_mode_dec)
	);

	// ****************************************
	// output registers
	// ****************************************
	// one registered stage keeps glitches off the analog controls when
	// several bits change in one write
	pllfb_pkg::pllfb_fb_ctrl_t fb_ctrl_reg;
	pllfb_pkg::pllfb_fb_ctrl_t fb_ctrl_next;
	logic                      changed_reg;
	logic                      changed_next;
	pllfb_pkg::pllfb_rx_mode_t zd_mode_reg;
	pllfb_pkg::pllfb_rx_mode_t zd_mode_next;
	pllfb_pkg::pllfb_rx_mode_t first_mode_reg;
	pllfb_pkg::pllfb_rx_mode_t first_mode_next;
	pllfb_pkg::pllfb_rx_mode_t second_mode_reg;
	pllfb_pkg::pllfb_rx_mode_t second_mode_next;

	always_comb begin
		fb_ctrl_next     = fb_dec;
		zd_mode_next     = zd_mode_dec;
		first_mode_next  = first_mode_dec;
		second_mode_next = second_mode_dec;
		// flags a feedback source switch so the loop can relock
		changed_next     = (fb_dec.fb_sel != fb_ctrl_reg.fb_sel);
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			fb_ctrl_reg.fb_sel         <= pllfb_pkg::PLLFB_FB_ZD_EXTERNAL;
			fb_ctrl_reg.zero_delay_en  <= 1'b1;
			fb_ctrl_reg.zd_rx_power_up <= 1'b1;
			changed_reg                <= 1'b0;
			zd_mode_reg                <= '0;
			first_mode_reg             <= '0;
			second_mode_reg            <= '0;
		end else begin
			fb_ctrl_reg     <= fb_ctrl_next;
			changed_reg     <= changed_next;
			zd_mode_reg     <= zd_mode_next;
			first_mode_reg  <= first_mode_next;
			second_mode_reg <= second_mode_next;
		end
	end

	assign fb_ctrl                     = fb_ctrl_reg;
	assign fb_path_changed             = changed_reg;
	assign zero_delay_input_mode       = zd_mode_reg;
	assign first_reference_input_mode  = first_mode_reg;
	assign second_reference_input_mode = second_mode_reg;

endmodule : pllfb_ctrl

/* File: core/pllfb_params.svh */
// constants for the input-loop feedback and receiver-mode register
// assumes inclusion by bare name from core/ and bench/ files
`ifndef PLLFB_PARAMS_SVH
`define PLLFB_PARAMS_SVH

// ****************************************
// register map
// ****************************************
`define PLLFB_ADDR_W            10
`define PLLFB_DATA_W            8
`define PLLFB_LOOP_FB_ADDR      10'h01b
`define PLLFB_LOOP_FB_RESET     8'h00

// ****************************************
// field positions
// ****************************************
`define PLLFB_BIT_FIRST_REF_PIN 0
`define PLLFB_BIT_SECOND_REF_PIN 1
`define PLLFB_BIT_ZD_DIFF       2
`define PLLFB_BIT_ZD_PIN        3
`define PLLFB_BIT_FB_OSC        4
`define PLLFB_BIT_ZD_INTERNAL   5
`define PLLFB_RSVD_MSB          7
`define PLLFB_RSVD_LSB          6

// ****************************************
// timing
// ****************************************
`define PLLFB_CLK_PERIOD_NS     100

`endif

/* File: core/pllfb_pkg.sv */
// types for the input-loop feedback and receiver-mode block
// assumes nothing beyond a SystemVerilog compiler
package pllfb_pkg;

	// ****************************************
	// feedback path choice
	// ****************************************
	typedef enum logic [1:0] {
		PLLFB_FB_OSC,
		PLLFB_FB_ZD_INTERNAL,
		PLLFB_FB_ZD_EXTERNAL
	} pllfb_fb_sel_t;

	// ****************************************
	// decoded controls
	// ****************************************
	typedef struct packed {
		pllfb_fb_sel_t fb_sel;
		logic          zero_delay_en;
		logic          zd_rx_power_up;
	} pllfb_fb_ctrl_t;

	typedef struct packed {
		logic powered;
		logic diff_mode;
		logic pos_pin_en;
		logic neg_pin_en;
	} pllfb_rx_mode_t;

endpackage : pllfb_pkg

/* File: core/pllfb_rx_mode.sv */
// one input receiver's mode decode: differential or one chosen single-ended pin
// assumes diff_en and pin_sel come from stored register bits
`timescale 1ns/1ps

module pllfb_rx_mode (
	// control
	input  wire logic                     powered,
	input  wire logic                     diff_en,
	input  wire logic                     pin_sel,
	// decoded mode
	output pllfb_pkg::pllfb_rx_mode_t     mode
);

	always_comb begin
		mode.powered    = powered;
		mode.diff_mode  = powered & diff_en;
		// pin choice only counts in single-ended mode
		mode.pos_pin_en = powered & ~diff_en & ~pin_sel;
		mode.neg_pin_en = powered & ~diff_en & pin_sel;
	end

endmodule : pllfb_rx_mode
